// ==== spb_checker_sva.sv ====
// Purpose: bus and pin ownership checks
// Assumes: control and port direction shadowed from taken bus writes
// Notes: bind at the foot
`include "spb_params.svh"
module spb_checker #(
  parameter int unsigned HALF_DIV = `SPB_HALF_DIV
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        irq_o,
  // pins
  input wire logic        ss_i,
  input wire logic        miso_oe_o,
  input wire logic        mosi_o,
  input wire logic        mosi_oe_o,
  input wire logic        sck_oe_o,
  input wire logic        ss_oe_o
);
  logic [5:0] ctrl_reg;
  logic [5:0] ctrl_next;
  logic [3:0] dir_reg;
  logic [3:0] dir_next;
  logic       take;
  logic       wr;
  logic       slv;
  logic       mst;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr   = take && wb_we_i && wb_sel_i[0];
  assign slv  = ctrl_reg[`SPB_CTRL_EN] && !ctrl_reg[`SPB_CTRL_MSTR];
  // master, detection off: enable cannot drop
  assign mst  = ctrl_reg[`SPB_CTRL_EN] && ctrl_reg[`SPB_CTRL_MSTR] && !ctrl_reg[`SPB_CTRL_FDE];
  always_comb begin
    ctrl_next = ctrl_reg;
    dir_next  = dir_reg;
    if (wr && wb_adr_i == `SPB_OFF_CTRL) ctrl_next = wb_dat_i[5:0];
    if (wr && wb_adr_i == `SPB_OFF_PORT_DIR) dir_next = wb_dat_i[3:0];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `SPB_CTRL_RST;
      dir_reg  <= 4'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      dir_reg  <= dir_next;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one pulse");
  a_slave_miso_hiz: assert property ((slv && ss_i) [*6] |-> !miso_oe_o)
    else $error("deselected slave drives miso");
  a_slave_miso_drive: assert property ((slv && !ss_i) [*6] |-> miso_oe_o)
    else $error("selected slave leaves miso released");
  a_slave_pins_in: assert property (slv [*2] |-> !sck_oe_o && !mosi_oe_o && !ss_oe_o)
    else $error("slave drives clock, mosi or select");
  a_master_pins_out: assert property (mst [*2] |-> sck_oe_o && !miso_oe_o && (ctrl_reg[4] || mosi_oe_o))
    else $error("master pin directions wrong");
  a_master_ss_port: assert property (mst [*2] |-> ss_oe_o == dir_reg[`SPB_PIN_SS])
    else $error("master select not port I/O");
  a_wom_open_drain: assert property (mst && ctrl_reg[`SPB_CTRL_WOM] |-> !(mosi_oe_o && mosi_o))
    else $error("wired-or mosi driven high");
  a_disabled_port: assert property (!ctrl_reg[0] [*2] |-> {ss_oe_o, sck_oe_o, mosi_oe_o, miso_oe_o} == dir_reg)
    else $error("disabled pins not port I/O");
  c_slave_drive: cover property (slv && miso_oe_o);
  c_master_run: cover property (mst && sck_oe_o && mosi_oe_o);
  c_wom_low: cover property (mst && ctrl_reg[`SPB_CTRL_WOM] && mosi_oe_o);
  c_irq: cover property ($rose(irq_o));
endmodule

bind spi_pin_select_break_control spb_checker #(.HALF_DIV(HALF_DIV)) i_spb_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
  .ss_i(ss_i), .miso_oe_o(miso_oe_o), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .sck_oe_o(sck_oe_o),
  .ss_oe_o(ss_oe_o)
);

// ==== spb_far_model.sv ====
// Purpose: far SPI device on the four pins, slave or master role
// Assumes: clock polarity 0, phase 1, most significant bit first
// Notes: released lines fall back to the bench pull-ups
module spb_far_model (
  // wire levels
  input  wire logic sck_i,
  input  wire logic mosi_i,
  input  wire logic miso_i,
  // driven by this device
  output logic      sck_o,
  output logic      ss_o,
  output logic      mosi_o,
  output logic      mosi_oe_o,
  output logic      miso_o,
  output logic      miso_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       slave_en;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  int         edges;
  assign miso_oe_o = slave_en;
  initial begin
    sck_o = 1'b0;
    ss_o = 1'b1;
    mosi_o = 1'b0;
    mosi_oe_o = 1'b0;
    miso_o = 1'b0;
    slave_en = 1'b0;
    tx_byte = 8'h00;
    rx_byte = 8'h00;
    edges = 0;
  end
  // slave role: drive on lead, sample on trail
  always @(posedge sck_i) begin
    if (slave_en) begin
      miso_o  <= tx_byte[7];
      tx_byte <= {tx_byte[6:0], ~tx_byte[7]};
      edges   <= edges + 1;
    end
  end
  always @(negedge sck_i) begin
    if (slave_en) begin
      rx_byte <= {rx_byte[6:0], mosi_i};
    end
  end
  // master role: one frame, clock idle low outside it
  task automatic master_xfer(input logic [7:0] tx, input int nbits, input logic sel);
    ss_o = sel;
    mosi_oe_o = 1'b1;
    #80;
    for (int i = 0; i < nbits; i++) begin
      mosi_o = tx[7-i];
      sck_o = 1'b1;
      #80;
      rx_byte = {rx_byte[6:0], miso_i};
      sck_o = 1'b0;
      #80;
    end
    mosi_oe_o = 1'b0;
    #80;
    ss_o = 1'b1;
    #160;
  endtask
endmodule

// ==== spb_params.svh ====
// Purpose: constants of the SPI pin/break block
// Assumes: byte addresses, one register per word
// Notes: included by bare name
`ifndef SPB_PARAMS_SVH
`define SPB_PARAMS_SVH

// register byte offsets
`define SPB_OFF_CTRL      8'h00
`define SPB_OFF_STAT      8'h04
`define SPB_OFF_DATA      8'h08
`define SPB_OFF_PORT_DIR  8'h0C
`define SPB_OFF_PORT_DATA 8'h10
`define SPB_OFF_IRQ_STAT  8'h14
`define SPB_OFF_IRQ_MASK  8'h18

// control register fields
`define SPB_CTRL_W        6
`define SPB_CTRL_EN       0
`define SPB_CTRL_MSTR     1
`define SPB_CTRL_CPOL     2
`define SPB_CTRL_PHASE_SELECT     3
`define SPB_CTRL_WOM      4
`define SPB_CTRL_FDE      5
`define SPB_CTRL_RST      6'h0A

// status register fields
`define SPB_STAT_TXE      0
`define SPB_STAT_RXF      1
`define SPB_STAT_OVR      2
`define SPB_STAT_FLT      3
`define SPB_STAT_BUSY     4

// event bits, shared by irq status and irq mask
`define SPB_EV_W          4
`define SPB_EV_TX         0
`define SPB_EV_RX         1
`define SPB_EV_OVR        2
`define SPB_EV_FLT        3

// pin index inside the four-pin port
`define SPB_PIN_MISO      0
`define SPB_PIN_MOSI      1
`define SPB_PIN_SCK       2
`define SPB_PIN_SS        3
`define SPB_PIN_RST       4'h8

// serial clock half period in bus clocks when master
`define SPB_HALF_DIV      8

`endif

// ==== spb_pkg.sv ====
// Purpose: shared types of the SPI pin/break block
// Assumes: nothing
// Notes: constants live in spb_params.svh
package spb_pkg;
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_ACTIVE
  } xfer_state_e;
endpackage

// ==== spi_pin_select_break_control.sv ====
// Purpose: pin ownership, select roles, mode fault, break protection
// Assumes: pins asynchronous; break inputs on clk_i
// Notes: master sck half period is HALF_DIV clocks
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`include "spb_params.svh"

// Function
// - with break clear enable set, clears work in break and stay after it.
// - clear enable off: break accesses leave status flags unchanged.
// - first step of a two-step clear taken before break survives a protected break.
// - protected break data writes are dropped: no load, no start, transmit empty kept.
// - data output to master driven only as slave with select low, else released.
// - enabled unit owns MISO, MOSI and clock pin direction.
// - master shifts out on MOSI while sampling MISO, full duplex.
// - serial clock out as master, in as slave; eight clock cycles per byte.
// - as slave, select is always an input to the unit.
// - fault detection from select is gated by fault detect enable.
// - deselected slave ignores all clock edges, even mid-transfer.
// - master select is port I/O when detection off, input-only when on.
// - port data read shows select level when that bit is input.
// - wired-or select makes MOSI open-drain: pull low or release.
// - disabled unit returns all pins to port I/O and ignores select.
// - master with detection sets fault while select is low.
// - slave with detection sets fault if select rises mid-transfer.
module spi_pin_select_break_control #(
  parameter int unsigned HALF_DIV = `SPB_HALF_DIV
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // break control
  input  wire logic        break_i,
  input  wire logic        break_clear_enable_i,
  // interrupt
  output logic             irq_o,
  // MISO pin
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  // MOSI pin
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe_o,
  // serial clock pin
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_o,
  // select pin
  input  wire logic        ss_i,
  output logic             ss_o,
  output logic             ss_oe_o
);
  logic [3:0]                pin_f;
  logic                      ack_reg,       ack_next;
  logic [31:0]               dat_reg,       dat_next;
  logic [`SPB_CTRL_W-1:0]    ctrl_reg,      ctrl_next;
  logic [3:0]                port_dir_reg,  port_dir_next;
  logic [3:0]                port_out_reg,  port_out_next;
  logic [`SPB_EV_W-1:0]      mask_reg,      mask_next;
  logic [`SPB_EV_W-1:0]      ev_reg,        ev_next;
  logic [7:0]                tx_buf_reg,    tx_buf_next;
  logic                      tx_empty_reg,  tx_empty_next;
  logic [7:0]                rx_data_reg,   rx_data_next;
  logic                      rx_full_reg,   rx_full_next;
  logic                      ovr_reg,       ovr_next;
  logic                      fault_reg,     fault_next;
  logic                      fault_arm_reg, fault_arm_next;
  logic                      ovr_arm_reg,   ovr_arm_next;
  spb_pkg::xfer_state_e      state_reg,     state_next;
  logic [7:0]                sh_reg,        sh_next;
  logic [7:0]                rx_sh_reg,     rx_sh_next;
  logic [3:0]                bits_reg,      bits_next;
  logic [15:0]               div_reg,       div_next;
  logic                      sck_reg,       sck_next;
  logic                      sck_prev_reg,  sck_prev_next;
  logic                      ss_prev_reg,   ss_prev_next;
  logic                      req, rd, wr, protect;
  logic                      en, ms, cpol, phase_select, fde;
  logic                      lead, trail, samp, shft, din, done;
  logic                      slave_sel, mfault, sfault;
  logic [`SPB_EV_W-1:0]      ev_set;
  logic [7:0]                rx_final;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction

  spi_pin_sync #(
    .WIDTH   (4),
    .RST_VAL (`SPB_PIN_RST)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({ss_i, sck_i, mosi_i, miso_i}),
    .level_o (pin_f)
  );

  assign req     = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign rd      = req & ~wb_we_i;
  assign wr      = req & wb_we_i & wb_sel_i[0];
  assign protect = break_i & ~break_clear_enable_i;
  assign en      = ctrl_reg[`SPB_CTRL_EN];
  assign ms      = ctrl_reg[`SPB_CTRL_MSTR];
  assign cpol    = ctrl_reg[`SPB_CTRL_CPOL];
  assign phase_select    = ctrl_reg[`SPB_CTRL_PHASE_SELECT];
  assign fde     = ctrl_reg[`SPB_CTRL_FDE];
  // select only matters to an enabled unit
  assign slave_sel = en & ~ms & ~pin_f[`SPB_PIN_SS];
  assign mfault    = en & ms & fde & ~pin_f[`SPB_PIN_SS];
  assign sfault    = en & ~ms & fde & (state_reg == spb_pkg::ST_ACTIVE)
                     & pin_f[`SPB_PIN_SS] & ~ss_prev_reg;

  always_comb begin
    ack_next       = req;
    dat_next       = dat_reg;
    ctrl_next      = ctrl_reg;
    port_dir_next  = port_dir_reg;
    port_out_next  = port_out_reg;
    mask_next      = mask_reg;
    ev_next        = ev_reg;
    tx_buf_next    = tx_buf_reg;
    tx_empty_next  = tx_empty_reg;
    rx_data_next   = rx_data_reg;
    rx_full_next   = rx_full_reg;
    ovr_next       = ovr_reg;
    fault_next     = fault_reg;
    fault_arm_next = fault_arm_reg;
    ovr_arm_next   = ovr_arm_reg;
    state_next     = state_reg;
    sh_next        = sh_reg;
    rx_sh_next     = rx_sh_reg;
    bits_next      = bits_reg;
    div_next       = div_reg;
    sck_next       = sck_reg;
    sck_prev_next  = pin_f[`SPB_PIN_SCK];
    ss_prev_next   = pin_f[`SPB_PIN_SS];
    lead           = 1'b0;
    trail          = 1'b0;
    done           = 1'b0;
    samp           = 1'b0;
    shft           = 1'b0;
    ev_set         = '0;
    din            = ms ? pin_f[`SPB_PIN_MISO] : pin_f[`SPB_PIN_MOSI];
    rx_final       = rx_sh_reg;

    // read data and read side effects
    if (rd) begin
      case (wb_adr_i)
        `SPB_OFF_CTRL:      dat_next = {26'h0, ctrl_reg};
        `SPB_OFF_STAT:      dat_next = {27'h0, state_reg == spb_pkg::ST_ACTIVE, fault_reg, ovr_reg,
                                        rx_full_reg, tx_empty_reg};
        `SPB_OFF_DATA:      dat_next = {24'h0, rx_data_reg};
        `SPB_OFF_PORT_DIR:  dat_next = {28'h0, port_dir_reg};
        `SPB_OFF_PORT_DATA: dat_next = {28'h0, (port_dir_reg & port_out_reg) | (~port_dir_reg & pin_f)};
        `SPB_OFF_IRQ_STAT:  dat_next = {28'h0, ev_reg};
        `SPB_OFF_IRQ_MASK:  dat_next = {28'h0, mask_reg};
        default:            dat_next = 32'h0;
      endcase
    end
    if (rd && !protect && hit(wb_adr_i, `SPB_OFF_STAT)) begin
      if (fault_reg) begin
        fault_arm_next = 1'b1;
      end
      if (ovr_reg) begin
        ovr_arm_next = 1'b1;
      end
    end
    if (rd && !protect && hit(wb_adr_i, `SPB_OFF_DATA)) begin
      rx_full_next = 1'b0;
      if (ovr_arm_reg) begin
        ovr_next     = 1'b0;
        ovr_arm_next = 1'b0;
      end
    end

    // byte engine
    if (!en) begin
      state_next    = spb_pkg::ST_IDLE;
      tx_empty_next = 1'b1;
      sh_next       = 8'h00;
      bits_next     = 4'h0;
      sck_next      = cpol;
    end else begin
      case (state_reg)
        spb_pkg::ST_IDLE: begin
          sck_next = cpol;
          if (!tx_empty_reg) begin
            sh_next               = tx_buf_reg;
            tx_empty_next         = 1'b1;
            ev_set[`SPB_EV_TX]    = 1'b1;
          end
          if (ms && !tx_empty_reg) begin
            state_next = spb_pkg::ST_ACTIVE;
            div_next   = 16'(HALF_DIV - 1);
            bits_next  = 4'h0;
          end else if (!ms && slave_sel) begin
            // phase zero starts on select fall, one on first edge
            if ((!phase_select && ss_prev_reg) ||
                (phase_select && pin_f[`SPB_PIN_SCK] != sck_prev_reg && pin_f[`SPB_PIN_SCK] != cpol)) begin
              state_next = spb_pkg::ST_ACTIVE;
              bits_next  = 4'h0;
            end
          end
        end
        spb_pkg::ST_ACTIVE: begin
          if (ms) begin
            if (div_reg == 16'h0000) begin
              div_next = 16'(HALF_DIV - 1);
              sck_next = ~sck_reg;
              lead     = (sck_reg == cpol);
              trail    = (sck_reg != cpol);
            end else begin
              div_next = div_reg - 16'h0001;
            end
          end else if (slave_sel && pin_f[`SPB_PIN_SCK] != sck_prev_reg) begin
            lead  = (pin_f[`SPB_PIN_SCK] != cpol);
            trail = (pin_f[`SPB_PIN_SCK] == cpol);
          end
          if (!ms && !phase_select && slave_sel && ss_prev_reg) begin
            bits_next = 4'h0;
          end
          samp = phase_select ? trail : lead;
          shft = phase_select ? lead : trail;
          if (samp) begin
            rx_final   = {rx_sh_reg[6:0], din};
            rx_sh_next = rx_final;
            bits_next  = bits_reg + 4'h1;
            if (phase_select && bits_reg == 4'h7) begin
              done = 1'b1;
            end
          end
          if (shft) begin
            if (!phase_select && bits_reg == 4'h8) begin
              done = 1'b1;
            end else if (!phase_select || bits_reg != 4'h0) begin
              sh_next = {sh_reg[6:0], 1'b0};
            end
          end
          if (done) begin
            state_next = spb_pkg::ST_IDLE;
            if (rx_full_next) begin
              ovr_next            = 1'b1;
              ev_set[`SPB_EV_OVR] = 1'b1;
            end else begin
              rx_data_next        = rx_final;
              rx_full_next        = 1'b1;
              ev_set[`SPB_EV_RX]  = 1'b1;
            end
          end
        end
        default: begin
          state_next = spb_pkg::ST_IDLE;
        end
      endcase
    end

    // register writes
    if (wr) begin
      case (wb_adr_i)
        `SPB_OFF_CTRL: begin
          ctrl_next = wb_dat_i[`SPB_CTRL_W-1:0];
          if (fault_arm_reg && !protect && !mfault && !sfault) begin
            fault_next     = 1'b0;
            fault_arm_next = 1'b0;
          end
        end
        `SPB_OFF_DATA: begin
          if (!protect) begin
            tx_buf_next   = wb_dat_i[7:0];
            tx_empty_next = 1'b0;
          end
        end
        `SPB_OFF_PORT_DIR:  port_dir_next = wb_dat_i[3:0];
        `SPB_OFF_PORT_DATA: port_out_next = wb_dat_i[3:0];
        `SPB_OFF_IRQ_STAT: begin
          if (!protect) begin
            ev_next = ev_reg & ~wb_dat_i[`SPB_EV_W-1:0];
          end
        end
        `SPB_OFF_IRQ_MASK:  mask_next = wb_dat_i[`SPB_EV_W-1:0];
        default: begin
        end
      endcase
    end

    // fault set wins over clear; master fault drops the enable
    if (mfault || sfault) begin
      fault_next          = 1'b1;
      ev_set[`SPB_EV_FLT] = 1'b1;
    end
    if (mfault) begin
      ctrl_next[`SPB_CTRL_EN] = 1'b0;
    end
    ev_next = ev_next | ev_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg       <= 1'b0;
      dat_reg       <= 32'h0;
      ctrl_reg      <= `SPB_CTRL_RST;
      port_dir_reg  <= 4'h0;
      port_out_reg  <= 4'h0;
      mask_reg      <= '0;
      ev_reg        <= '0;
      tx_buf_reg    <= 8'h00;
      tx_empty_reg  <= 1'b1;
      rx_data_reg   <= 8'h00;
      rx_full_reg   <= 1'b0;
      ovr_reg       <= 1'b0;
      fault_reg     <= 1'b0;
      fault_arm_reg <= 1'b0;
      ovr_arm_reg   <= 1'b0;
      state_reg     <= spb_pkg::ST_IDLE;
      sh_reg        <= 8'h00;
      rx_sh_reg     <= 8'h00;
      bits_reg      <= 4'h0;
      div_reg       <= 16'h0000;
      sck_reg       <= 1'b0;
      sck_prev_reg  <= 1'b0;
      ss_prev_reg   <= 1'b1;
    end else begin
      ack_reg       <= ack_next;
      dat_reg       <= dat_next;
      ctrl_reg      <= ctrl_next;
      port_dir_reg  <= port_dir_next;
      port_out_reg  <= port_out_next;
      mask_reg      <= mask_next;
      ev_reg        <= ev_next;
      tx_buf_reg    <= tx_buf_next;
      tx_empty_reg  <= tx_empty_next;
      rx_data_reg   <= rx_data_next;
      rx_full_reg   <= rx_full_next;
      ovr_reg       <= ovr_next;
      fault_reg     <= fault_next;
      fault_arm_reg <= fault_arm_next;
      ovr_arm_reg   <= ovr_arm_next;
      state_reg     <= state_next;
      sh_reg        <= sh_next;
      rx_sh_reg     <= rx_sh_next;
      bits_reg      <= bits_next;
      div_reg       <= div_next;
      sck_reg       <= sck_next;
      sck_prev_reg  <= sck_prev_next;
      ss_prev_reg   <= ss_prev_next;
    end
  end

  // port I/O unless the enabled unit claims the pin
  always_comb begin
    miso_o    = port_out_reg[`SPB_PIN_MISO];
    miso_oe_o = port_dir_reg[`SPB_PIN_MISO];
    mosi_o    = port_out_reg[`SPB_PIN_MOSI];
    mosi_oe_o = port_dir_reg[`SPB_PIN_MOSI];
    sck_o     = port_out_reg[`SPB_PIN_SCK];
    sck_oe_o  = port_dir_reg[`SPB_PIN_SCK];
    ss_o      = port_out_reg[`SPB_PIN_SS];
    ss_oe_o   = port_dir_reg[`SPB_PIN_SS];
    if (en) begin
      miso_o    = sh_reg[7];
      miso_oe_o = slave_sel;
      mosi_o    = ctrl_reg[`SPB_CTRL_WOM] ? 1'b0 : sh_reg[7];
      mosi_oe_o = ms & (ctrl_reg[`SPB_CTRL_WOM] ? ~sh_reg[7] : 1'b1);
      sck_o     = sck_reg;
      sck_oe_o  = ms;
      if (!ms || fde) begin
        ss_o    = 1'b0;
        ss_oe_o = 1'b0;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o    = |(ev_reg & mask_reg);
endmodule

// ==== spi_pin_select_break_control_test.sv ====
// Purpose: self-checking bench of the SPI pin/break block
// Assumes: far model on the pins, pull-ups on the MISO and MOSI lines only
// Notes: expected values from the register map
`include "spb_params.svh"
module spi_pin_select_break_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, break_i, break_clear_enable_i, irq_o;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic        miso_i, miso_o, miso_oe_o, mosi_i, mosi_o, mosi_oe_o, sck_i, sck_o, sck_oe_o, ss_i, ss_o, ss_oe_o;
  logic        f_sck, f_ss, f_mosi, f_mosi_oe, f_miso, f_miso_oe;
  int          fails, cmp_count;
  assign miso_i = miso_oe_o ? miso_o : (f_miso_oe ? f_miso : 1'b1);
  assign mosi_i = mosi_oe_o ? mosi_o : (f_mosi_oe ? f_mosi : 1'b1);
  assign sck_i  = sck_oe_o ? sck_o : f_sck;
  assign ss_i   = ss_oe_o ? ss_o : f_ss;
  spi_pin_select_break_control #(.HALF_DIV(8)) i_spi_pin_select_break_control (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .break_i(break_i), .break_clear_enable_i(break_clear_enable_i), .irq_o(irq_o),
    .miso_i(miso_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o), .mosi_i(mosi_i), .mosi_o(mosi_o),
    .mosi_oe_o(mosi_oe_o), .sck_i(sck_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .ss_i(ss_i), .ss_o(ss_o),
    .ss_oe_o(ss_oe_o));
  spb_far_model i_far (.sck_i(sck_i), .mosi_i(mosi_i), .miso_i(miso_i), .sck_o(f_sck), .ss_o(f_ss),
    .mosi_o(f_mosi), .mosi_oe_o(f_mosi_oe), .miso_o(f_miso), .miso_oe_o(f_miso_oe));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    if (wb_ack_o !== 1'b1) fails++;
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask
  task automatic stat_bit(input int b, input logic e);
    rd(`SPB_OFF_STAT, q);
    check(32'(q[b]), 32'(e));
  endtask
  task automatic master_byte(input logic [7:0] tx, input logic [7:0] rx, input logic keep);
    int n;
    i_far.tx_byte = rx;
    i_far.edges = 0;
    i_far.slave_en = 1'b1;
    wr(`SPB_OFF_DATA, {24'h0, tx});
    n = 0;
    q = 32'h0;
    while (q[`SPB_STAT_RXF] !== 1'b1 && n < 100) begin
      rd(`SPB_OFF_STAT, q);
      n++;
    end
    if (!keep) begin
      rd(`SPB_OFF_DATA, q);
      check(q, {24'h0, rx});
    end
    check({24'h0, i_far.rx_byte}, {24'h0, tx});
    check(32'(i_far.edges), 32'h8);
    i_far.slave_en = 1'b0;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    end_of_test();
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, break_i, break_clear_enable_i} = 6'h20;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    fails = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SPB_OFF_CTRL, q);
    check(q, 32'hA);
    rd(`SPB_OFF_STAT, q);
    check(q, 32'h1);
    wr(8'h1C, 32'hFF);
    rd(8'h1C, q);
    check(q, 32'h0);
    check({28'h0, ss_oe_o, sck_oe_o, mosi_oe_o, miso_oe_o}, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      wr(`SPB_OFF_IRQ_MASK, 32'h0);
      wr(`SPB_OFF_CTRL, i ? 32'h1B : 32'h0B);
      master_byte(i ? 8'h96 : 8'h3C, i ? 8'h69 : 8'hA5, 1'b0);
      check(32'(irq_o), 32'h0);
      wr(`SPB_OFF_IRQ_MASK, 32'h2);
      check(32'(irq_o), 32'h1);
      rd(`SPB_OFF_IRQ_STAT, q);
      check(q, 32'h3);
      wr(`SPB_OFF_IRQ_STAT, 32'h3);
      check(32'(irq_o), 32'h0);
    end
    $display("test master done");
    wr(`SPB_OFF_CTRL, 32'h09);
    wr(`SPB_OFF_DATA, 32'h5A);
    check(32'(miso_oe_o), 32'h0);
    i_far.master_xfer(8'hC3, 8, 1'b0);
    check({24'h0, i_far.rx_byte}, 32'h5A);
    rd(`SPB_OFF_DATA, q);
    check(q, 32'hC3);
    i_far.master_xfer(8'h0F, 8, 1'b1);
    stat_bit(`SPB_STAT_RXF, 1'b0);
    i_far.master_xfer(8'hF0, 4, 1'b0);
    stat_bit(`SPB_STAT_FLT, 1'b0);
    wr(`SPB_OFF_CTRL, 32'h08);
    wr(`SPB_OFF_CTRL, 32'h29);
    i_far.master_xfer(8'hF0, 4, 1'b0);
    stat_bit(`SPB_STAT_FLT, 1'b1);
    wr(`SPB_OFF_CTRL, 32'h08);
    stat_bit(`SPB_STAT_FLT, 1'b0);
    $display("test slave done");
    wr(`SPB_OFF_CTRL, 32'h0B);
    wr(`SPB_OFF_PORT_DIR, 32'h8);
    wr(`SPB_OFF_PORT_DATA, 32'h0);
    check({30'h0, ss_oe_o, ss_o}, 32'h2);
    repeat (8) @(posedge clk_i);
    stat_bit(`SPB_STAT_FLT, 1'b0);
    wr(`SPB_OFF_PORT_DIR, 32'h0);
    i_far.ss_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd(`SPB_OFF_PORT_DATA, q);
    check(32'(q[`SPB_PIN_SS]), 32'h0);
    wr(`SPB_OFF_IRQ_STAT, 32'hF);
    wr(`SPB_OFF_IRQ_MASK, 32'h8);
    wr(`SPB_OFF_CTRL, 32'h2B);
    check(32'(ss_oe_o), 32'h0);
    repeat (8) @(posedge clk_i);
    stat_bit(`SPB_STAT_FLT, 1'b1);
    rd(`SPB_OFF_CTRL, q);
    check(q, 32'h2A);
    check(32'(irq_o), 32'h1);
    i_far.ss_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd(`SPB_OFF_PORT_DATA, q);
    check(32'(q[`SPB_PIN_SS]), 32'h1);
    $display("test fault done");
    rd(`SPB_OFF_STAT, q);
    @(posedge clk_i);
    break_i <= 1'b1;
    wr(`SPB_OFF_CTRL, 32'h0B);
    wr(`SPB_OFF_DATA, 32'h77);
    wr(`SPB_OFF_IRQ_STAT, 32'h8);
    repeat (8) @(posedge clk_i);
    rd(`SPB_OFF_STAT, q);
    check(q & 32'h19, 32'h09);
    check(32'(irq_o), 32'h1);
    @(posedge clk_i);
    break_i <= 1'b0;
    wr(`SPB_OFF_CTRL, 32'h0B);
    stat_bit(`SPB_STAT_FLT, 1'b0);
    wr(`SPB_OFF_IRQ_STAT, 32'h8);
    check(32'(irq_o), 32'h0);
    master_byte(8'h81, 8'h18, 1'b1);
    @(posedge clk_i);
    break_i <= 1'b1;
    break_clear_enable_i <= 1'b1;
    rd(`SPB_OFF_DATA, q);
    check(q, 32'h18);
    @(posedge clk_i);
    break_i <= 1'b0;
    stat_bit(`SPB_STAT_RXF, 1'b0);
    $display("test break done");
    end_of_test();
  end
endmodule

// ==== spi_pin_sync.sv ====
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to clk_i
// Notes: output moves only once stages two and three agree
module spi_pin_sync #(
  parameter int unsigned     WIDTH   = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // pins in, filtered level out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] mid_reg;
  logic [WIDTH-1:0] late_reg;
  logic [WIDTH-1:0] level_reg;
  logic [WIDTH-1:0] level_next;

  always_comb begin
    level_next = level_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (mid_reg[i] == late_reg[i]) begin
        level_next[i] = late_reg[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg  <= RST_VAL;
      mid_reg   <= RST_VAL;
      late_reg  <= RST_VAL;
      level_reg <= RST_VAL;
    end else begin
      meta_reg  <= async_i;
      mid_reg   <= meta_reg;
      late_reg  <= mid_reg;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;
endmodule
